/* File: hdl/ts_framer_regs.svh */
// Offsets, field positions, reset values and counts of the downstream framer.
// Assumes 32-bit APB words on aligned byte addresses.
`ifndef TS_FRAMER_REGS_SVH
`define TS_FRAMER_REGS_SVH
`define TS_PKT_LAST 8'd187
`define TS_HDR_LEN 8'd4
`define TS_PAYLOAD_LEN 16'd184
`define TS_SYNC 8'h47
`define TS_MAC_PID 13'h1ffe
`define TS_NULL_PID 13'h1fff
`define TS_FILL 8'hff
`define TS_SCR_BITS 2'b00
`define TS_AFC_PAYLOAD 2'b01
`define TS_LOCK_GOOD 3'd5
`define TS_LOSE_BAD 4'd9
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_RX_STAT 12'h008
`define REG_TX_STAT 12'h00c
`define CTRL_RESET 2'h3
`define CTRL_TX_EN_BIT 0
`define CTRL_RX_EN_BIT 1
`endif

/* File: hdl/ts_framer_pkg.sv */
// Types shared by the downstream transport stream framer.
// Assumes nothing beyond a SystemVerilog compiler.
package ts_framer_pkg;
  typedef enum logic [1:0] {align_hunt, align_verify, align_locked} align_e;
  typedef enum logic {pkt_null, pkt_mac} pkt_kind_e;
endpackage

/* File: hdl/downstream_ts_framer.sv */
// Downstream transmission convergence: MAC frames into 188-byte transport packets and back.
// Assumes one clock; MAC source, MAC sink and modulation side are logic on that clock.
`timescale 1ns/10ps
`include "ts_framer_regs.svh"
module downstream_ts_framer import ts_framer_pkg::*; #(
  parameter int BYTE_DIV = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] mac_tx_data,
  input wire logic mac_tx_valid,
  input wire logic mac_tx_sof,
  input wire logic [15:0] mac_tx_len,
  output logic mac_tx_ready,
  output logic mac_tx_frame_sent,
  output logic [7:0] ts_out_data,
  output logic ts_out_valid,
  output logic ts_out_sop,
  input wire logic [7:0] ts_in_data,
  input wire logic ts_in_valid,
  output logic [7:0] mac_rx_data,
  output logic mac_rx_valid,
  output logic mac_rx_sof,
  input wire logic mac_rx_frame_end,
  output logic rx_locked
);
  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [1:0] ctrl;
  logic [15:0] rx_err_cnt, rx_loss_cnt, tx_mac_cnt, tx_null_cnt;
  logic [3:0] tx_cc;
  logic [15:0] tx_remain;
  logic rx_in_frame;
  wire tx_en = ctrl[`CTRL_TX_EN_BIT];
  wire rx_en = ctrl[`CTRL_RX_EN_BIT];
  wire sel_ctrl = paddr == `REG_CTRL;
  wire sel_status = paddr == `REG_STATUS;
  wire sel_rx = paddr == `REG_RX_STAT;
  wire sel_tx = paddr == `REG_TX_STAT;
  wire mapped = sel_ctrl || sel_status || sel_rx || sel_tx;
  wire setup = psel && !penable;
  wire wr = psel && penable && pready && pwrite;
  wire clr_rx = wr && sel_rx;
  wire clr_tx = wr && sel_tx;
  wire [31:0] status_word = {24'h000000, tx_cc, 1'b0, tx_remain != 16'h0000, rx_in_frame, rx_locked};
  wire [31:0] rd_word = sel_ctrl ? {30'h00000000, ctrl} :
                        sel_status ? status_word :
                        sel_rx ? {rx_loss_cnt, rx_err_cnt} :
                        sel_tx ? {tx_null_cnt, tx_mac_cnt} : 32'h00000000;
  // Zero wait state: answer is ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      ctrl <= `CTRL_RESET;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_word;
        pslverr <= !mapped;
      end
      if (wr && sel_ctrl) begin
        ctrl <= pwdata[1:0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Byte rate divider
  logic [7:0] div_cnt;
  wire tick = div_cnt == 8'(BYTE_DIV - 1);
  wire pre_tick = div_cnt == 8'(BYTE_DIV - 2);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Sender
  logic [7:0] tx_pos, tx_ptr, next_tx_byte;
  logic tx_pusi;
  pkt_kind_e tx_kind;
  wire take = mac_tx_valid && mac_tx_ready;
  wire tx_use = take && (tx_remain != 16'h0000 || mac_tx_sof);
  wire start_frame = take && mac_tx_sof && tx_remain == 16'h0000;
  wire [15:0] frame_len = mac_tx_len == 16'h0000 ? 16'h0001 : mac_tx_len;
  wire new_mac = tx_en && (tx_remain != 16'h0000 || mac_tx_valid);
  wire is_mac = tx_kind == pkt_mac;
  wire ptr_slot = is_mac && tx_pusi && tx_pos == `TS_HDR_LEN;
  wire data_slot = is_mac && tx_pos >= `TS_HDR_LEN && !ptr_slot;
  wire [12:0] tx_pid = is_mac ? `TS_MAC_PID : `TS_NULL_PID;
  wire [7:0] tx_pos_inc = tx_pos == `TS_PKT_LAST ? 8'h00 : tx_pos + 8'h01;
  wire [15:0] next_remain = start_frame ? frame_len - 16'h0001 :
                            (take && tx_remain != 16'h0000) ? tx_remain - 16'h0001 : tx_remain;
  always_comb begin
    case (tx_pos)
      8'h00: next_tx_byte = `TS_SYNC;
      8'h01: next_tx_byte = {1'b0, tx_pusi, 1'b0, tx_pid[12:8]};
      8'h02: next_tx_byte = tx_pid[7:0];
      8'h03: next_tx_byte = {`TS_SCR_BITS, `TS_AFC_PAYLOAD, is_mac ? tx_cc : 4'h0};
      default: begin
        if (ptr_slot) begin
          next_tx_byte = tx_ptr;
        end else if (tx_use) begin
          next_tx_byte = mac_tx_data;
        end else begin
          next_tx_byte = `TS_FILL;
        end
      end
    endcase
  end
  // Pointer decided at packet start from the tail still owed; a tail of 184 or more needs no pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pos <= 8'h00;
      tx_kind <= pkt_null;
      tx_pusi <= 1'b0;
      tx_ptr <= 8'h00;
      tx_cc <= 4'h0;
      tx_remain <= 16'h0000;
    end else if (tick) begin
      tx_pos <= tx_pos_inc;
      tx_remain <= next_remain;
      if (tx_pos == 8'h00) begin
        tx_kind <= new_mac ? pkt_mac : pkt_null;
        tx_pusi <= new_mac && tx_remain < `TS_PAYLOAD_LEN;
        tx_ptr <= tx_remain[7:0];
      end
      if (tx_pos == 8'h03 && is_mac) begin
        tx_cc <= tx_cc + 4'h1;
      end
    end
  end
  // Ready is a one-cycle pulse on the tick that carries a data slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_out_data <= 8'h00;
      ts_out_valid <= 1'b0;
      ts_out_sop <= 1'b0;
      mac_tx_ready <= 1'b0;
      mac_tx_frame_sent <= 1'b0;
    end else begin
      if (tick) begin
        ts_out_data <= next_tx_byte;
      end
      ts_out_valid <= tick;
      ts_out_sop <= tick && tx_pos == 8'h00;
      mac_tx_ready <= pre_tick && data_slot;
      mac_tx_frame_sent <= tick && start_frame;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_mac_cnt <= 16'h0000;
      tx_null_cnt <= 16'h0000;
    end else begin
      if (tick && tx_pos == 8'h00 && new_mac) begin
        tx_mac_cnt <= (clr_tx ? 16'h0000 : tx_mac_cnt) + 16'h0001;
      end else if (clr_tx) begin
        tx_mac_cnt <= 16'h0000;
      end
      if (tick && tx_pos == 8'h00 && !new_mac) begin
        tx_null_cnt <= (clr_tx ? 16'h0000 : tx_null_cnt) + 16'h0001;
      end else if (clr_tx) begin
        tx_null_cnt <= 16'h0000;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Receiver alignment
  align_e rx_state, next_state;
  logic [7:0] rx_pos, next_pos;
  logic [2:0] rx_good, next_good;
  logic [3:0] rx_bad, next_bad;
  wire rv = ts_in_valid && rx_en;
  wire is_sync = ts_in_data == `TS_SYNC;
  wire at_zero = rx_pos == 8'h00;
  wire [7:0] rx_pos_inc = rx_pos == `TS_PKT_LAST ? 8'h00 : rx_pos + 8'h01;
  wire lose_lock = rv && rx_state == align_locked && at_zero && !is_sync && rx_bad == `TS_LOSE_BAD - 4'd1;
  always_comb begin
    next_state = rx_state;
    next_pos = rx_pos;
    next_good = rx_good;
    next_bad = rx_bad;
    if (rv) begin
      next_pos = rx_pos_inc;
      case (rx_state)
        align_hunt: begin
          next_pos = 8'h01;
          next_good = 3'd1;
          next_bad = 4'd0;
          if (is_sync) begin
            next_state = align_verify;
          end
        end
        align_verify: begin
          if (at_zero && is_sync) begin
            next_good = rx_good + 3'd1;
            if (next_good == `TS_LOCK_GOOD) begin
              next_state = align_locked;
            end
          end else if (at_zero) begin
            next_state = align_hunt;
          end
        end
        align_locked: begin
          if (at_zero) begin
            next_bad = is_sync ? 4'd0 : rx_bad + 4'd1;
          end
          if (lose_lock) begin
            next_state = align_hunt;
          end
        end
        default: next_state = align_hunt;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= align_hunt;
      rx_pos <= 8'h00;
      rx_good <= 3'd0;
      rx_bad <= 4'd0;
      rx_locked <= 1'b0;
    end else begin
      rx_state <= rx_en ? next_state : align_hunt;
      rx_pos <= next_pos;
      rx_good <= next_good;
      rx_bad <= next_bad;
      rx_locked <= rx_state == align_locked;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Receiver payload
  // Frame length is only known to the sink, so it ends each frame with mac_rx_frame_end
  logic rx_sync_ok, rx_tei, rx_pusi, rx_pid_ok, rx_pkt_ok, rx_pend, rx_allow;
  logic [4:0] rx_pid_hi;
  logic [7:0] rx_skip;
  wire locked_byte = rv && rx_state == align_locked;
  wire hdr_err = locked_byte && rx_pos == 8'h03 && rx_sync_ok && rx_pid_ok && rx_tei;
  wire ptr_byte = locked_byte && rx_pkt_ok && rx_pusi && rx_pos == `TS_HDR_LEN;
  wire payload_byte = locked_byte && rx_pkt_ok && rx_pos >= `TS_HDR_LEN && !ptr_byte;
  wire in_skip = rx_skip != 8'h00;
  // End pulse may land with the next byte at the fastest byte rate, so it closes the frame at once
  wire frame_open = rx_in_frame && !mac_rx_frame_end;
  wire searching = !in_skip && (!frame_open || rx_pend);
  wire deliver_tail = payload_byte && (in_skip ? frame_open : frame_open && !rx_pend);
  wire deliver_sof = payload_byte && searching && rx_allow && ts_in_data != `TS_FILL;
  wire drop_frame = lose_lock || hdr_err || !rx_en;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sync_ok <= 1'b0;
      rx_tei <= 1'b0;
      rx_pusi <= 1'b0;
      rx_pid_hi <= 5'h00;
      rx_pid_ok <= 1'b0;
      rx_pkt_ok <= 1'b0;
    end else if (locked_byte) begin
      case (rx_pos)
        8'h00: begin
          rx_sync_ok <= is_sync;
          rx_pkt_ok <= 1'b0;
        end
        8'h01: begin
          rx_tei <= ts_in_data[7];
          rx_pusi <= ts_in_data[6];
          rx_pid_hi <= ts_in_data[4:0];
        end
        8'h02: rx_pid_ok <= {rx_pid_hi, ts_in_data} == `TS_MAC_PID;
        8'h03: rx_pkt_ok <= rx_sync_ok && rx_pid_ok && !rx_tei && ts_in_data[5:4] == `TS_AFC_PAYLOAD;
        default: rx_pkt_ok <= rx_pkt_ok;
      endcase
    end
  end
  // A sof found while a frame is still open means the sink missed its end; the new start wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_in_frame <= 1'b0;
      rx_pend <= 1'b0;
      rx_allow <= 1'b0;
      rx_skip <= 8'h00;
    end else begin
      if (drop_frame) begin
        rx_in_frame <= 1'b0;
      end else if (deliver_sof) begin
        rx_in_frame <= 1'b1;
      end else if (mac_rx_frame_end || (payload_byte && searching)) begin
        rx_in_frame <= 1'b0;
      end
      if (ptr_byte) begin
        rx_skip <= ts_in_data;
        rx_pend <= 1'b1;
        rx_allow <= 1'b1;
      end else begin
        if (payload_byte && in_skip) begin
          rx_skip <= rx_skip - 8'h01;
        end
        if (payload_byte && !in_skip) begin
          rx_pend <= 1'b0;
        end
        if (drop_frame) begin
          rx_allow <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_rx_data <= 8'h00;
      mac_rx_valid <= 1'b0;
      mac_rx_sof <= 1'b0;
      rx_err_cnt <= 16'h0000;
      rx_loss_cnt <= 16'h0000;
    end else begin
      mac_rx_data <= ts_in_data;
      mac_rx_valid <= deliver_tail || deliver_sof;
      mac_rx_sof <= deliver_sof;
      if (hdr_err) begin
        rx_err_cnt <= (clr_rx ? 16'h0000 : rx_err_cnt) + 16'h0001;
      end else if (clr_rx) begin
        rx_err_cnt <= 16'h0000;
      end
      if (lose_lock) begin
        rx_loss_cnt <= (clr_rx ? 16'h0000 : rx_loss_cnt) + 16'h0001;
      end else if (clr_rx) begin
        rx_loss_cnt <= 16'h0000;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_sync_first: assert property (tick && tx_pos == 8'h00 |=> ts_out_sop && ts_out_data == `TS_SYNC)
    else $error("sync byte missing");
  a_pkt_wrap: assert property (tick && tx_pos == `TS_PKT_LAST |=> tx_pos == 8'h00)
    else $error("packet length wrong");
  a_flag_zero: assert property (tick && tx_pos == 8'h01 |=> !ts_out_data[7] && !ts_out_data[5])
    else $error("error or priority bit set");
  a_pid_low: assert property (tick && tx_pos == 8'h02 && is_mac |=> ts_out_data == 8'hfe)
    else $error("mac identifier wrong");
  a_afc_bits: assert property (tick && tx_pos == 8'h03 |=> ts_out_data[7:4] == 4'h1)
    else $error("scramble or adaptation bits wrong");
  a_cc_step: assert property (tick && tx_pos == 8'h03 && is_mac |=> tx_cc == $past(tx_cc) + 4'h1)
    else $error("continuity counter did not step");
  a_ptr_value: assert property (tick && ptr_slot |=> ts_out_data == $past(tx_ptr) ##1 !ts_out_valid)
    else $error("pointer byte wrong");
  a_fill_gap: assert property (tick && tx_pos > `TS_HDR_LEN && !tx_use |=> ts_out_data == `TS_FILL)
    else $error("gap not filled");
  a_lock_five: assert property (rv && rx_state == align_verify && at_zero && is_sync && rx_good == 3'd4
    |=> rx_state == align_locked ##1 rx_locked)
    else $error("lock not declared");
  a_loss_nine: assert property (lose_lock |=> rx_state == align_hunt && !rx_in_frame)
    else $error("lock not dropped");
  a_no_fill_sof: assert property (mac_rx_sof |-> mac_rx_valid && mac_rx_data != `TS_FILL)
    else $error("fill passed as frame start");
  c_locked: cover property (rx_state == align_verify ##1 rx_state == align_locked);
  c_tx_frame: cover property (mac_tx_frame_sent);
  c_rx_frame: cover property (mac_rx_sof ##[1:200] mac_rx_valid);
  c_null_pkt: cover property (tick && tx_pos == 8'h00 && !new_mac);

endmodule

/* File: tb/mac_partner.sv */
// MAC sublayer model: frame source toward the framer, frame sink behind the receiver.
// Assumes the bench fills tx_q (sof, length, byte) and len_q by hierarchical reference.
`timescale 1ns/10ps
module mac_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mac_tx_ready,
  output logic [7:0] mac_tx_data,
  output logic mac_tx_valid,
  output logic mac_tx_sof,
  output logic [15:0] mac_tx_len,
  input wire logic mac_rx_valid,
  input wire logic mac_rx_sof,
  output logic mac_rx_frame_end
);
  logic [24:0] tx_q[$];
  int len_q[$];
  int left;
  ////////////////////////////////////////
  // Whole frame is queued up front, so no offered slot inside a frame goes empty
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_tx_valid <= 1'b0;
      mac_tx_sof <= 1'b0;
      mac_tx_len <= 16'h0000;
      mac_tx_data <= 8'h00;
    end else begin
      if (mac_tx_valid && mac_tx_ready) begin
        void'(tx_q.pop_front());
      end
      if (tx_q.size() > 0) begin
        {mac_tx_sof, mac_tx_len, mac_tx_data} <= tx_q[0];
        mac_tx_valid <= 1'b1;
      end else begin
        mac_tx_valid <= 1'b0;
        mac_tx_sof <= 1'b0;
        // Idle byte toggles so a stale byte never looks valid
        mac_tx_data <= ~mac_tx_data;
      end
    end
  end
  ////////////////////////////////////////
  // Sink knows each frame length, as a real MAC would from its header
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_rx_frame_end <= 1'b0;
      left = 0;
    end else begin
      mac_rx_frame_end <= 1'b0;
      if (mac_rx_valid === 1'b1) begin
        if (mac_rx_sof === 1'b1 && len_q.size() > 0) left = len_q.pop_front();
        left = left - 1;
        if (left == 0) mac_rx_frame_end <= 1'b1;
      end
    end
  end
endmodule

/* File: tb/tb.sv */
// Self-checking bench: transport stream looped back into the receiver, MAC model on both sides.
// Assumes the framer, its package and its register header are compiled before this file.
`timescale 1ns/10ps
`include "ts_framer_regs.svh"
module tb;
  localparam int DIV = 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] mac_tx_data, ts_out_data, ts_in_data, mac_rx_data, d, hb1;
  logic mac_tx_valid, mac_tx_sof, mac_tx_ready, mac_tx_frame_sent, ts_out_valid, ts_out_sop;
  logic ts_in_valid, mac_rx_valid, mac_rx_sof, mac_rx_frame_end, rx_locked, lk_d, tei_req, cc_seen;
  logic [15:0] mac_tx_len;
  logic [12:0] pid;
  logic [3:0] cc_prev;
  logic [8:0] exp_q[$];
  logic [8:0] e9;
  logic [7:0] sent_q[$];
  logic [32:0] rd_q[$];
  logic [32:0] e33;
  int bad_count, n_checks, opos, ipos, bad_left, bad_run, sync_cnt;

  downstream_ts_framer #(.BYTE_DIV(DIV)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mac_tx_data, .mac_tx_valid, .mac_tx_sof, .mac_tx_len, .mac_tx_ready,
    .mac_tx_frame_sent, .ts_out_data, .ts_out_valid, .ts_out_sop, .ts_in_data, .ts_in_valid, .mac_rx_data,
    .mac_rx_valid, .mac_rx_sof, .mac_rx_frame_end, .rx_locked);
  mac_partner mac_u (.pclk, .presetn, .mac_tx_ready, .mac_tx_data, .mac_tx_valid, .mac_tx_sof, .mac_tx_len,
    .mac_rx_valid, .mac_rx_sof, .mac_rx_frame_end);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task end_of_test;
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Idle cycle after each transfer keeps psel from being driven twice in one step
  task apb(input logic [11:0] a, input logic w, input logic [31:0] wd, input logic [32:0] ex);
    if (!w) rd_q.push_back(ex);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task send_frame(input int n, input bit note);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = (i == 0) ? 8'($urandom % 255) : 8'($urandom);
      mac_u.tx_q.push_back({i == 0, 16'(n), b});
      if (note) exp_q.push_back({i == 0, b});
      if (i == 0) sent_q.push_back(b);
    end
    if (note) mac_u.len_q.push_back(n);
  endtask

  task wait_lock(input logic v);
    for (int k = 0; k < 20000 && rx_locked !== v; k++) @(posedge pclk);
    chk("lock_state", rx_locked, v);
  endtask

  task wait_drain;
    for (int k = 0; k < 40000 && exp_q.size() > 0; k++) @(posedge pclk);
    chk("drained", exp_q.size(), 0);
  endtask
  ////////////////////////////////////////
  always @(posedge pclk) begin
    if (ts_out_valid === 1'b1) begin
      if (ts_out_sop === 1'b1) begin
        chk("pkt_len", opos, 188);
        chk("sync", ts_out_data, `TS_SYNC);
        opos = 0;
      end
      case (opos)
        1: begin
          hb1 = ts_out_data;
          chk("tei_prio", {ts_out_data[7], ts_out_data[5]}, 2'b00);
        end
        2: pid = {hb1[4:0], ts_out_data};
        3: begin
          chk("scr_afc", ts_out_data[7:4], {`TS_SCR_BITS, `TS_AFC_PAYLOAD});
          if (pid == `TS_MAC_PID) begin
            if (cc_seen) chk("cc", ts_out_data[3:0], 4'(cc_prev + 4'd1));
            cc_prev = ts_out_data[3:0];
            cc_seen = 1'b1;
          end else chk("pid", pid, `TS_NULL_PID);
        end
        4: if (pid == `TS_MAC_PID && hb1[6]) chk("ptr", ts_out_data < 8'd184, 1'b1);
        default: if (opos > 4 && pid == `TS_NULL_PID) chk("fill", ts_out_data, `TS_FILL);
      endcase
      opos++;
    end
  end

  // Watcher: every result that appears takes the oldest note
  always @(posedge pclk) begin
    if (mac_tx_frame_sent === 1'b1) begin
      chk("sent_valid", ts_out_valid, 1'b1);
      chk("sent_byte", ts_out_data, sent_q.pop_front());
    end
    if (mac_rx_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("rx_extra", 0, 1);
      else begin
        e9 = exp_q.pop_front();
        chk("rx_byte", {mac_rx_sof, mac_rx_data}, e9);
      end
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e33 = rd_q.pop_front();
      chk("prdata", prdata, e33[31:0]);
      chk("pslverr", pslverr, e33[32]);
    end
  end

  // Loopback with sync and error-bit corruption on request
  always @(posedge pclk) begin
    d = ts_out_data;
    if (ts_out_valid === 1'b1) begin
      ipos = ts_out_sop ? 0 : ipos + 1;
      if (ipos == 0 && bad_left > 0) begin
        if (bad_left == 1) chk("lock_held", rx_locked, 1'b1);
        d = 8'h00;
        bad_left--;
        bad_run++;
      end
      if (ipos == 1 && tei_req && d[6]) begin
        d[7] = 1'b1;
        tei_req = 1'b0;
      end
      if (ipos == 0 && d == `TS_SYNC) sync_cnt++;
    end
    if (rx_locked === 1'b1 && !lk_d) chk("syncs_to_lock", sync_cnt, 5);
    if (rx_locked === 1'b0 && lk_d) begin
      chk("bad_to_loss", bad_run, 9);
      sync_cnt = 0;
      bad_run = 0;
    end
    lk_d = rx_locked;
    ts_in_data <= d;
    ts_in_valid <= ts_out_valid;
  end
  ////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, tei_req, lk_d, cc_seen, ts_in_valid} = '0;
    paddr = '0;
    pwdata = '0;
    ts_in_data = '0;
    presetn = 1'b0;
    opos = 188;
    void'($urandom(32'hb6898dc2));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(`REG_CTRL, 1'b0, 0, {31'h0, `CTRL_RESET});
    apb(12'h010, 1'b0, 0, {1'b1, 32'h0});
    apb(12'h010, 1'b1, 32'hffff_ffff, '0);
    wait_lock(1'b1);
    send_frame(1, 1);
    send_frame(2, 1);
    send_frame(3, 1);
    send_frame(400, 1);
    repeat (6) begin
      send_frame(1 + $urandom % 300, 1);
      repeat ($urandom % 400) @(posedge pclk);
    end
    wait_drain;
    repeat (2) @(posedge ts_out_sop);
    tei_req = 1'b1;
    send_frame(20, 0);
    repeat (2) @(posedge ts_out_sop);
    send_frame(50, 1);
    wait_drain;
    repeat (2) @(posedge ts_out_sop);
    bad_left = 9;
    wait_lock(1'b0);
    wait_lock(1'b1);
    apb(`REG_RX_STAT, 1'b0, 0, {1'b0, 16'd1, 16'd1});
    apb(`REG_RX_STAT, 1'b1, 0, '0);
    apb(`REG_RX_STAT, 1'b0, 0, '0);
    // Locked, no frame open, counter one past the last MAC header seen
    apb(`REG_STATUS, 1'b0, 0, {1'b0, 24'h000000, 4'(cc_prev + 4'd1), 4'h1});
    // Sender off, receiver on: lock stays, only null packets follow
    apb(`REG_CTRL, 1'b1, 32'h00000002, '0);
    apb(`REG_CTRL, 1'b0, 0, {31'h00000000, 2'h2});
    end_of_test;
  end

  // Whole run is near 12000 cycles; this bound leaves wide margin
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    end_of_test;
  end
endmodule
